// File: src/sbt_pkg.sv
// Package for the sixteen-bit general timer: register map, control fields, reset values.
// Assumes a 32-bit Avalon-MM slave with word addresses in bytes.
package sbt_pkg;

	// Register byte offsets.
	localparam logic [3:0] SBT_OFF_CONTROL = 4'h0;
	localparam logic [3:0] SBT_OFF_PERIOD  = 4'h4;
	localparam logic [3:0] SBT_OFF_COUNT   = 4'h8;
	localparam logic [3:0] SBT_OFF_STATUS  = 4'hC;
	localparam logic [3:0] SBT_OFF_MASK    = 4'h0; // Mask sits at offset 0x10, see high bit below.
	localparam logic [4:0] SBT_OFF_MASK_W  = 5'h10;
	localparam logic [4:0] SBT_OFF_IDLE    = 5'h14;

	// Control field positions.
	localparam int SBT_BIT_RUN   = 15;
	localparam int SBT_BIT_IDLE  = 13;
	localparam int SBT_BIT_GATE  = 6;
	localparam int SBT_BIT_PS_HI = 5;
	localparam int SBT_BIT_PS_LO = 4;
	localparam int SBT_BIT_SYNC  = 2;
	localparam int SBT_BIT_SRC   = 1;

	// Writable control bits; the rest read as zero.
	localparam logic [15:0] SBT_CONTROL_MASK = 16'hA076;

	// Reset values.
	localparam logic [15:0] SBT_CONTROL_RST = 16'h0000;
	localparam logic [15:0] SBT_PERIOD_RST  = 16'hFFFF;
	localparam logic [15:0] SBT_COUNT_RST   = 16'h0000;

	// Prescale terminal counts, one less than the ratio.
	localparam logic [7:0] SBT_PS_DIV1   = 8'h00;
	localparam logic [7:0] SBT_PS_DIV8   = 8'h07;
	localparam logic [7:0] SBT_PS_DIV64  = 8'h3F;
	localparam logic [7:0] SBT_PS_DIV256 = 8'hFF;

	// Status and mask bit positions.
	localparam int SBT_EV_MATCH = 0;
	localparam int SBT_EV_GATE  = 1;

	// Decoded control fields.
	typedef struct packed {
		logic       run;
		logic       idle_stop;
		logic       gated_accumulate;
		logic [1:0] prescale_select;
		logic       ext_clock_sync;
		logic       clock_source_select;
	} sbt_ctrl_t;

	// Sampled external inputs.
	typedef struct packed {
		logic count_pin;
		logic gate;
	} sbt_pins_t;

	// Avalon register phases.
	typedef enum logic [1:0] {
		SBT_BUS_IDLE = 2'b01,
		SBT_BUS_DONE = 2'b10
	} sbt_bus_t;

endpackage

// File: src/sbt_timer.sv
// Sixteen-bit general timer with prescaler, gating, idle stop and a sticky interrupt.
// Assumes a synchronous Avalon-MM master on REF_CLK and pins synchronous to REF_CLK.
//
// Function
// - One 16-bit counter: timer, sync, async counter.
// - Interrupt on period match or gate fall.
// - Bit 15 starts and stops the timer.
// - Bit 13 halts counting during idle.
// - Bit 6 gates only with internal source.
// - Bits 5-4 select 1, 8, 64, 256.
// - Bit 2 synchronises the external pin.
// - Bit 1 selects pin edges or internal.
// - Control write while running clears prescaler.
// - Unimplemented control bits read zero.
// - All control bits clear at reset.
//
// Decided for this implementation: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module sbt_timer
	import sbt_pkg::*;
(
	// Clock and reset.
	input  wire logic        REF_CLK,
	input  wire logic        RSTN,
	// Avalon-MM slave.
	input  wire logic [4:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output var  logic [31:0] AVS_READDATA,
	output var  logic        AVS_WAITREQUEST,
	// Timer pins and system state.
	input  wire logic        EXT_COUNT_PIN,
	input  wire logic        GATE_PIN,
	input  wire logic        CPU_IDLE,
	// Interrupt.
	output var  logic        IRQ
);

	sbt_bus_t    bus_q;
	logic [15:0] control_q;
	logic [15:0] period_q;
	logic [15:0] count_q;
	logic [1:0]  status_q;
	logic [1:0]  mask_q;
	logic [7:0]  prescale_q;
	sbt_pins_t   pins_q;
	sbt_pins_t   pins_prev_q;
	logic        sync_a_q;
	logic        sync_b_q;
	logic        sync_prev_q;
	sbt_ctrl_t   ctrl;
	logic        access;
	logic        wr_hit;
	logic        src_edge;
	logic        gate_ok;
	logic        active;
	logic        input_tick;
	logic [7:0]  ps_limit;
	logic        count_tick;
	logic        match_tick;
	logic        gate_fall;
	logic [15:0] wdata;

	// Control word decoded into named fields.
	assign ctrl.run                 = control_q[SBT_BIT_RUN];
	assign ctrl.idle_stop           = control_q[SBT_BIT_IDLE];
	assign ctrl.gated_accumulate    = control_q[SBT_BIT_GATE];
	assign ctrl.prescale_select     = control_q[SBT_BIT_PS_HI:SBT_BIT_PS_LO];
	assign ctrl.ext_clock_sync      = control_q[SBT_BIT_SYNC];
	assign ctrl.clock_source_select = control_q[SBT_BIT_SRC];

	// A request is accepted in the cycle it appears while idle; waitrequest drops for the one cycle after.
	// Writes commit only at the edge where the master sees waitrequest low, so a dropped request never lands.
	assign access = (AVS_READ | AVS_WRITE) & (bus_q == SBT_BUS_IDLE);
	assign wr_hit = AVS_WRITE & (bus_q == SBT_BUS_DONE);
	assign wdata  = {AVS_BYTEENABLE[1] ? AVS_WRITEDATA[15:8] : 8'h00,
	                 AVS_BYTEENABLE[0] ? AVS_WRITEDATA[7:0] : 8'h00};

	// Bus handshake: waitrequest high while idle, low for the single answering cycle.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			bus_q           <= SBT_BUS_IDLE;
			AVS_WAITREQUEST <= 1'b1;
		end else begin
			case (bus_q)
				SBT_BUS_IDLE: begin
					bus_q           <= access ? SBT_BUS_DONE : SBT_BUS_IDLE;
					AVS_WAITREQUEST <= ~access;
				end
				SBT_BUS_DONE: begin
					bus_q           <= SBT_BUS_IDLE;
					AVS_WAITREQUEST <= 1'b1;
				end
				default: begin
					bus_q           <= SBT_BUS_IDLE;
					AVS_WAITREQUEST <= 1'b1;
				end
			endcase
		end
	end

	// Read data are captured at acceptance and stand during the answering cycle.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			AVS_READDATA <= 32'h0000_0000;
		end else if (access && AVS_READ) begin
			case (AVS_ADDRESS)
				{1'b0, SBT_OFF_CONTROL}: AVS_READDATA <= {16'h0000, control_q & SBT_CONTROL_MASK};
				{1'b0, SBT_OFF_PERIOD}:  AVS_READDATA <= {16'h0000, period_q};
				{1'b0, SBT_OFF_COUNT}:   AVS_READDATA <= {16'h0000, count_q};
				{1'b0, SBT_OFF_STATUS}:  AVS_READDATA <= {30'h0000_0000, status_q};
				SBT_OFF_MASK_W:          AVS_READDATA <= {30'h0000_0000, mask_q};
				SBT_OFF_IDLE:            AVS_READDATA <= {31'h0000_0000, CPU_IDLE};
				default:                 AVS_READDATA <= 32'h0000_0000;
			endcase
		end
	end

	// Configuration registers; only implemented control bits are stored.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			control_q <= SBT_CONTROL_RST;
			period_q  <= SBT_PERIOD_RST;
			mask_q    <= 2'b00;
		end else if (wr_hit) begin
			if (AVS_ADDRESS == {1'b0, SBT_OFF_CONTROL}) control_q <= wdata & SBT_CONTROL_MASK;
			if (AVS_ADDRESS == {1'b0, SBT_OFF_PERIOD})  period_q  <= wdata;
			if (AVS_ADDRESS == SBT_OFF_MASK_W)         mask_q    <= wdata[1:0];
		end
	end

	// Pin sampling; the two-stage chain serves the synchronised external clock path.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			pins_q      <= '0;
			pins_prev_q <= '0;
			sync_a_q    <= 1'b0;
			sync_b_q    <= 1'b0;
			sync_prev_q <= 1'b0;
		end else begin
			pins_q      <= '{count_pin: EXT_COUNT_PIN, gate: GATE_PIN};
			pins_prev_q <= pins_q;
			sync_a_q    <= EXT_COUNT_PIN;
			sync_b_q    <= sync_a_q;
			sync_prev_q <= sync_b_q;
		end
	end

	// Source edge: internal ticks every cycle, or a rising pin edge, synchronised or direct.
	// Without a second clock domain the unsynchronised path is only one flop faster.
	always_comb begin
		if (ctrl.clock_source_select) begin
			if (ctrl.ext_clock_sync) src_edge = sync_b_q & ~sync_prev_q;
			else                     src_edge = pins_q.count_pin & ~pins_prev_q.count_pin;
		end else begin
			src_edge = 1'b1;
		end
	end

	// Gating and idle stop.
	assign gate_ok    = ~(ctrl.gated_accumulate & ~ctrl.clock_source_select) | pins_q.gate;
	assign active     = ctrl.run & ~(ctrl.idle_stop & CPU_IDLE);
	assign input_tick = active & src_edge & gate_ok;

	// Prescale ratio lookup.
	always_comb begin
		case (ctrl.prescale_select)
			2'b11:   ps_limit = SBT_PS_DIV256;
			2'b10:   ps_limit = SBT_PS_DIV64;
			2'b01:   ps_limit = SBT_PS_DIV8;
			default: ps_limit = SBT_PS_DIV1;
		endcase
	end

	assign count_tick = input_tick & (prescale_q >= ps_limit);
	assign match_tick = count_tick & (count_q == period_q);

	// Prescale counter; a control write while running restarts it.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			prescale_q <= 8'h00;
		end else if (wr_hit && AVS_ADDRESS == {1'b0, SBT_OFF_CONTROL} && ctrl.run) begin
			prescale_q <= 8'h00;
		end else if (!ctrl.run) begin
			prescale_q <= 8'h00;
		end else if (input_tick) begin
			prescale_q <= count_tick ? 8'h00 : prescale_q + 8'h01;
		end
	end

	// Main counter; software may load it, a tick at the period returns it to zero.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			count_q <= SBT_COUNT_RST;
		end else if (wr_hit && AVS_ADDRESS == {1'b0, SBT_OFF_COUNT}) begin
			count_q <= wdata;
		end else if (match_tick) begin
			count_q <= 16'h0000;
		end else if (count_tick) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// Gate falling edge only matters in gated internal mode.
	assign gate_fall = ctrl.run & ctrl.gated_accumulate & ~ctrl.clock_source_select
	                 & pins_prev_q.gate & ~pins_q.gate;

	// Sticky events: write one to clear, a new event in the same cycle wins.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) begin
			status_q <= 2'b00;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if ((i == SBT_EV_MATCH && match_tick) || (i == SBT_EV_GATE && gate_fall)) begin
					status_q[i] <= 1'b1;
				end else if (wr_hit && AVS_ADDRESS == {1'b0, SBT_OFF_STATUS} && wdata[i]) begin
					status_q[i] <= 1'b0;
				end
			end
		end
	end

	// Level interrupt, registered so the output comes from a flop.
	always_ff @(posedge REF_CLK or negedge RSTN) begin
		if (!RSTN) IRQ <= 1'b0;
		else       IRQ <= |(status_q & mask_q);
	end

endmodule
`default_nettype wire

// File: verif/sbt_timer_props.sv
// Checker for the timer's bus and interrupt ports.
// Assumes binding onto sbt_timer; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module sbt_props
	import sbt_pkg::*;
(
	// Clock, reset and the watched ports.
	input wire logic        REF_CLK,
	input wire logic        RSTN,
	input wire logic [4:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        IRQ
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RSTN);
	// A taken request gets exactly one low cycle of waitrequest.
	sequence s_take; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST; endsequence
	sequence s_answer; !AVS_WAITREQUEST ##1 AVS_WAITREQUEST; endsequence
	wire logic rd_ans = AVS_READ && !AVS_WAITREQUEST;
	a_bus_answer: assert property (s_take |=> s_answer) else $error("bus answer late or long");
	a_bus_quiet: assert property (!AVS_READ && !AVS_WRITE && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer without request");
	a_ctrl_zero: assert property (rd_ans && AVS_ADDRESS == 5'h00 |->
		(AVS_READDATA & ~{16'h0000, SBT_CONTROL_MASK}) == 32'h0) else $error("control spare bits set");
	a_upper_zero: assert property (rd_ans |-> AVS_READDATA[31:16] == 16'h0000) else $error("upper half set");
	a_unmapped_zero: assert property (rd_ans && AVS_ADDRESS > 5'h14 |-> AVS_READDATA == 32'h0)
		else $error("unmapped read not zero");
	a_data_stands: assert property (!AVS_READ && !$past(AVS_READ) |-> $stable(AVS_READDATA))
		else $error("read data moved");
	a_irq_fall: assert property ($fell(IRQ) |-> $past(AVS_WRITE) || $past(AVS_WRITE, 2))
		else $error("interrupt dropped without a write");
	a_irq_reset: assert property ($rose(RSTN) |-> !IRQ ##1 !IRQ) else $error("interrupt after reset");
endmodule
bind sbt_timer sbt_props u_props (.REF_CLK, .RSTN, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
	.AVS_WAITREQUEST, .IRQ);
`default_nettype wire

// File: verif/sbt_timer_tb_top.sv
// Self-checking bench for the sixteen-bit general timer.
// Assumes the bench alone drives the bus and the pins of one dut.
`timescale 1ns/1ps
`default_nettype none
module sbt_timer_tb_top import sbt_pkg::*; ;
	logic        ref_clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0, ext = 1'b0, gate = 1'b0, idle = 1'b0;
	logic [4:0]  adr = 5'h00;
	logic [31:0] wd = 32'h0, rdata, q;
	logic        waitreq, irq;
	logic [15:0] cv;
	int          fail_count = 0, n_compared = 0, cycles = 0, n, ps;
	sbt_timer dut (.REF_CLK(ref_clk), .RSTN(rstn), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
		.EXT_COUNT_PIN(ext), .GATE_PIN(gate), .CPU_IDLE(idle), .IRQ(irq));
	// Clock at 100 ns.
	initial forever #50 ref_clk = ~ref_clk;
	// The cycle ceiling cuts a hang short.
	always @(posedge ref_clk) begin
		cycles <= cycles + 1;
		if (cycles > 60000) begin
			fail_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		$display("Compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// One transfer; it waits an edge first so no signal is assigned twice in one step.
	// The wait is open ended; only the bench's cycle ceiling cuts a hung answer short.
	task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		adr <= a;
		wd <= {16'h0000, d};
		wr <= w;
		rd <= !w;
		do @(posedge ref_clk); while (waitreq !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		bus(1'b0, a, 16'h0000);
		chk(q, e);
	endtask
	// Each pulse is high one cycle and low one cycle, so every rising edge is seen on both paths.
	task automatic pulse(input int k);
		repeat (k) begin
			@(posedge ref_clk) ext <= 1'b1;
			@(posedge ref_clk) ext <= 1'b0;
		end
		repeat (4) @(posedge ref_clk);
	endtask
	function automatic int ratio(input int p);
		return p == 3 ? 256 : p == 2 ? 64 : p == 1 ? 8 : 1;
	endfunction
	// Reset, then the scenarios in turn.
	initial begin
		void'($urandom(41));
		repeat (20) @(posedge ref_clk);
		rstn <= 1'b1;
		rchk(5'h00, 32'h0);
		rchk(5'h04, 32'h0000FFFF);
		rchk(5'h18, 32'h0);
		bus(1'b1, 5'h00, 16'hFFFF);
		rchk(5'h00, {16'h0000, SBT_CONTROL_MASK});
		// Random pin-clocked modes; run, idle stop and the ignored gate bit are drawn too.
		for (int t = 0; t < 12; t++) begin
			cv = (16'($urandom) & 16'hA074) | 16'h0002;
			idle <= 1'($urandom);
			gate <= 1'($urandom);
			bus(1'b1, 5'h00, 16'h0000);
			bus(1'b1, 5'h08, 16'h0000);
			bus(1'b1, 5'h00, cv);
			ps = int'(cv[5:4]);
			n = $urandom_range(3 * ratio(ps), 1);
			pulse(n);
			rchk(5'h08, (!cv[15] || (cv[13] && idle)) ? 32'h0 : 32'(n / ratio(ps)));
		end
		// A control write while running restarts the prescaler.
		idle <= 1'b0;
		bus(1'b1, 5'h00, 16'h0000);
		bus(1'b1, 5'h08, 16'h0000);
		bus(1'b1, 5'h00, 16'h8012);
		pulse(5);
		bus(1'b1, 5'h00, 16'h8012);
		pulse(7);
		rchk(5'h08, 32'h0);
		// Period match sets the sticky flag; the mask gates the interrupt and a one clears it.
		n = $urandom_range(9, 2);
		bus(1'b1, 5'h00, 16'h0000);
		bus(1'b1, 5'h08, 16'h0000);
		bus(1'b1, 5'h0C, 16'h0003);
		bus(1'b1, 5'h04, 16'(n));
		bus(1'b1, 5'h00, 16'h8002);
		pulse(n - 1);
		rchk(5'h0C, 32'h0);
		pulse(3);
		rchk(5'h0C, 32'h1);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 5'h10, 16'h0001);
		bus(1'b1, 5'h00, 16'h0000);
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 5'h0C, 16'h0001);
		rchk(5'h0C, 32'h0);
		chk({31'h0, irq}, 32'h0);
		// Gated accumulation on the internal clock; the gate's fall raises the second flag.
		gate <= 1'b0;
		bus(1'b1, 5'h08, 16'h0000);
		bus(1'b1, 5'h04, 16'hFFFF);
		bus(1'b1, 5'h10, 16'h0002);
		bus(1'b1, 5'h00, 16'h8040);
		repeat (20) @(posedge ref_clk);
		rchk(5'h08, 32'h0);
		gate <= 1'b1;
		repeat (20) @(posedge ref_clk);
		gate <= 1'b0;
		bus(1'b0, 5'h08, 16'h0000);
		chk(q, 32'd20);
		rchk(5'h0C, 32'h2);
		chk({31'h0, irq}, 32'h1);
		finish_test();
	end
endmodule
`default_nettype wire
